// ---- inc/qeq_consts.vh ----
/*
  Constants of the quad equalizer management block: register offsets,
  field positions, reset values, threshold tables and bus timing.
  Assumes inclusion by src/qeq_mgmt.v only; holds definitions and nothing else.
*/
`ifndef QEQ_CONSTS_VH
`define QEQ_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define QEQ_REG_STATUS 8'h00
`define QEQ_REG_RB01 8'h01
`define QEQ_REG_RB23 8'h02
`define QEQ_REG_EB01 8'h03
`define QEQ_REG_EB23 8'h04
`define QEQ_REG_ATHR 8'h05
`define QEQ_REG_RTHR 8'h06
`define QEQ_REG_CTRL 8'h07
`define QEQ_REG_OLVL 8'h08

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define QEQ_RST_EB 8'h44
`define QEQ_RST_THR 8'h00
`define QEQ_RST_CTRL 1'h0
`define QEQ_RST_OLVL 8'h78
`define QEQ_OLVL_LO 2
`define QEQ_OLVL_HI 3
`define QEQ_OLVL_RSVD_MASK 8'hF3
`define QEQ_BOOST_DEF 3'h4
`define QEQ_BOOST_MIN 3'h0
`define QEQ_BOOST_MAX 3'h7

// ----------------------------------------------------------------------
// detect thresholds in mV, indexed by the 2-bit code
// ----------------------------------------------------------------------
`define QEQ_ON_MV0 8'h46
`define QEQ_ON_MV1 8'h37
`define QEQ_ON_MV2 8'h5A
`define QEQ_ON_MV3 8'h4B
`define QEQ_OFF_MV0 8'h28
`define QEQ_OFF_MV1 8'h1E
`define QEQ_OFF_MV2 8'h37
`define QEQ_OFF_MV3 8'h2D

// ----------------------------------------------------------------------
// bus timing: clock-low timeout and system clock rate
// ----------------------------------------------------------------------
`define QEQ_TMO_MS 25
`define QEQ_SYS_CLK_KHZ 100000

`endif

// ---- src/qeq_mgmt.v ----
/*
  Management and control logic of a four-channel equalizer: serial bus target, register set,
  pin/register selection of boost and enable, and signal detect with hysteresis.
  Assumes clk_sys at 100 MHz; bus and control pins are asynchronous and synchronised here;
  per-channel input amplitude in mV comes from a front-end measurement already on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "qeq_consts.vh"

// How it works
// RL1: bus port answers only while the port-select pin is high.
// RL2: standby powers a channel's datapath down; bus and detect keep running.
// RL3: boost-source pin high: three boost pins set boost for all channels.
// RL4: boost-source pin low: each channel's boost comes from its register field.
// RL5: boost is a 3-bit code, 000 minimum, 111 maximum, 100 default.
// RL6: control bit 0: enable pin high gives active, low gives standby.
// RL7: control bit 1: pins ignored, enable bit 0 active, 1 standby.
// RL8: register 0x07 bit 0 is the register-control enable, reset 0.
// RL9: detect rises above assert threshold, falls only below lower release threshold.
// RL10: detect state drives its own pin and status bits 3:0 of 0x00.
// RL11: register 0x00 bits 7:4 give a read-only revision field.
// RL12: registers 0x01 and 0x02 read back each channel's enable and boost.
// RL13: registers 0x03 and 0x04 hold enable and boost pairs, reset 0x44.
// RL14: register 0x05 holds 2-bit assert thresholds, codes 70/55/90/75 mV.
// RL15: register 0x06 holds 2-bit release thresholds, codes 40/30/55/45 mV.
// RL16: register 0x08 bits 3:2 set output level for all, reset 0x78.
// RL17: board may tie detect output to enable pin for automatic enable.
// RL18: controller should put unused channels into standby.
// RL19: bus clock held low for the timeout interval aborts the transaction.
// RL20: byte-data read and write target; reserved bits read zero, ignore writes; register 0x08 reserved bits read 0x70 here.

module qeq_mgmt #(
  parameter [6:0] BUS_ADDR = 7'h5A,      // arbitrary target address
  parameter [3:0] REVISION = 4'h0,       // arbitrary revision value
  parameter integer TMO_MS = `QEQ_TMO_MS,
  parameter integer TMO_CYC = TMO_MS * `QEQ_SYS_CLK_KHZ
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // management bus pins
  input wire port_select_pin,
  input wire mgmt_bus_clock_pin,
  input wire mgmt_bus_data_in,
  output wire mgmt_bus_data_out,
  output wire mgmt_bus_data_oe,
  // control pins
  input wire boost_source_pin,
  input wire [2:0] boost_level_pins,
  input wire [3:0] channel_enable_pin,
  // front-end amplitude per channel, mV, channel n in bits 8n+7:8n
  input wire [31:0] chan_amp_mv,
  // datapath controls and detect outputs
  output wire [3:0] chan_powered,
  output wire [11:0] chan_boost,
  output wire [1:0] out_level,
  output wire [3:0] signal_present_output
);

  // ----------------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_CMD = 4'h3;
  localparam [3:0] S_CACK = 4'h4;
  localparam [3:0] S_WDAT = 4'h5;
  localparam [3:0] S_WACK = 4'h6;
  localparam [3:0] S_RDAT = 4'h7;
  localparam [3:0] S_RACK = 4'h8;
  localparam [3:0] S_SBIT = 4'h9; // waits out the clock fall that ends a start
  localparam [7:0] OLVL_RST = `QEQ_RST_OLVL;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [1:0] cs_sync_q, scl_sync_q, sda_sync_q, feb_sync_q, olvl_q, lvl_q;
  reg [5:0] bst_sync_q;
  reg [7:0] en_sync_q, sh_q, tx_q, ptr_q, eb01_q, eb23_q, athr_q, rthr_q;
  reg scl_prev_q, sda_prev_q, rw_q, nack_q, oe_q, ctrl_q;
  reg [3:0] st_q, sd_q, pwr_q, standby_d, sd_d;
  reg [2:0] cnt_q;
  reg [31:0] tmo_q;
  reg [11:0] boost_q, boost_d;
  wire cs_s, scl_s, sda_s, feb_s, scl_rise, scl_fall, bus_start, bus_stop, tmo_hit;
  wire [2:0] bst_s;
  wire [3:0] en_s;
  wire [7:0] rd_cur, rd_nxt;
  wire [11:0] reg_boost;
  integer i;

  // synchronised pin levels, read only from the second stage
  assign cs_s = cs_sync_q[1];
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign feb_s = feb_sync_q[1];
  assign bst_s = bst_sync_q[5:3];
  assign en_s = en_sync_q[7:4];

  // ----------------------------------------------------------------------
  // threshold tables
  // ----------------------------------------------------------------------
  function [7:0] on_mv;
    input [1:0] code;
    begin
      case (code)
        2'h0: on_mv = `QEQ_ON_MV0;
        2'h1: on_mv = `QEQ_ON_MV1;
        2'h2: on_mv = `QEQ_ON_MV2;
        default: on_mv = `QEQ_ON_MV3;
      endcase
    end
  endfunction

  function [7:0] off_mv;
    input [1:0] code;
    begin
      case (code)
        2'h0: off_mv = `QEQ_OFF_MV0;
        2'h1: off_mv = `QEQ_OFF_MV1;
        2'h2: off_mv = `QEQ_OFF_MV2;
        default: off_mv = `QEQ_OFF_MV3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // two-stage synchronisers for every pin
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_sync_q <= 2'h0;
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      feb_sync_q <= 2'h3;
      bst_sync_q <= 6'h00;
      en_sync_q <= 8'h00;
      scl_prev_q <= 1'b1; // idle level, so no false edge after reset
      sda_prev_q <= 1'b1;
    end else begin
      cs_sync_q <= {cs_sync_q[0], port_select_pin};
      scl_sync_q <= {scl_sync_q[0], mgmt_bus_clock_pin};
      sda_sync_q <= {sda_sync_q[0], mgmt_bus_data_in};
      feb_sync_q <= {feb_sync_q[0], boost_source_pin};
      bst_sync_q <= {bst_sync_q[2:0], boost_level_pins};
      en_sync_q <= {en_sync_q[3:0], channel_enable_pin};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // edge and condition detection on the synchronised bus lines
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------------
  // clock-low timeout counter
  // ----------------------------------------------------------------------
  assign tmo_hit = (tmo_q >= TMO_CYC); // RL19

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmo_q <= 32'h0;
    end else if (scl_s || st_q == S_IDLE) begin
      tmo_q <= 32'h0;
    end else if (!tmo_hit) begin
      tmo_q <= tmo_q + 32'h1; // RL19
    end
  end

  // ----------------------------------------------------------------------
  // register read multiplexer
  // ----------------------------------------------------------------------
  function [7:0] rd_byte;
    input [7:0] a;
    begin
      case (a)
        `QEQ_REG_STATUS: rd_byte = {REVISION, sd_q}; // RL10 RL11
        `QEQ_REG_RB01: rd_byte = {~pwr_q[1], boost_q[5:3], ~pwr_q[0], boost_q[2:0]}; // RL12
        `QEQ_REG_RB23: rd_byte = {~pwr_q[3], boost_q[11:9], ~pwr_q[2], boost_q[8:6]}; // RL12
        `QEQ_REG_EB01: rd_byte = eb01_q;
        `QEQ_REG_EB23: rd_byte = eb23_q;
        `QEQ_REG_ATHR: rd_byte = athr_q;
        `QEQ_REG_RTHR: rd_byte = rthr_q;
        `QEQ_REG_CTRL: rd_byte = {7'h00, ctrl_q}; // RL20
        `QEQ_REG_OLVL: rd_byte = (OLVL_RST & `QEQ_OLVL_RSVD_MASK) | {4'h0, olvl_q, 2'h0}; // RL16
        default: rd_byte = 8'h00; // RL20
      endcase
    end
  endfunction

  // byte to send now and the one after it, for the first bit of a read
  assign rd_cur = rd_byte(ptr_q);
  assign rd_nxt = rd_byte(ptr_q + 8'h01);

  // ----------------------------------------------------------------------
  // bus target state machine
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      eb01_q <= `QEQ_RST_EB;
      eb23_q <= `QEQ_RST_EB;
      athr_q <= `QEQ_RST_THR;
      rthr_q <= `QEQ_RST_THR;
      ctrl_q <= `QEQ_RST_CTRL;
      olvl_q <= OLVL_RST[`QEQ_OLVL_HI:`QEQ_OLVL_LO];
    end else if (!cs_s || tmo_hit || bus_stop) begin
      st_q <= S_IDLE; // RL1 RL19
      oe_q <= 1'b0;
    end else if (bus_start) begin
      st_q <= S_SBIT; // address bits follow the start's own clock fall
      cnt_q <= 3'h0;
      oe_q <= 1'b0;
    end else if (scl_rise) begin
      // sample data on the rising bus clock
      cnt_q <= cnt_q + 3'h1;
      sh_q <= {sh_q[6:0], sda_s};
      if (st_q == S_RACK)
        nack_q <= sda_s;
    end else if (scl_fall) begin
      // drive data and acknowledge on the falling bus clock
      case (st_q)
        S_SBIT: st_q <= S_ADDR;
        S_ADDR: begin
          if (cnt_q == 3'h0) begin
            if (sh_q[7:1] == BUS_ADDR) begin
              rw_q <= sh_q[0];
              oe_q <= 1'b1;
              st_q <= S_AACK;
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        S_AACK: begin
          cnt_q <= 3'h0;
          if (rw_q) begin
            tx_q <= rd_cur; // RL20
            oe_q <= ~rd_cur[7];
            st_q <= S_RDAT;
          end else begin
            oe_q <= 1'b0;
            st_q <= S_CMD;
          end
        end
        S_CMD: begin
          if (cnt_q == 3'h0) begin
            ptr_q <= sh_q;
            oe_q <= 1'b1;
            st_q <= S_CACK;
          end
        end
        S_CACK: begin
          oe_q <= 1'b0;
          cnt_q <= 3'h0;
          st_q <= S_WDAT;
        end
        S_WDAT: begin
          if (cnt_q == 3'h0) begin
            oe_q <= 1'b1;
            st_q <= S_WACK;
            case (ptr_q)
              `QEQ_REG_EB01: eb01_q <= sh_q; // RL13
              `QEQ_REG_EB23: eb23_q <= sh_q; // RL13
              `QEQ_REG_ATHR: athr_q <= sh_q; // RL14
              `QEQ_REG_RTHR: rthr_q <= sh_q; // RL15
              `QEQ_REG_CTRL: ctrl_q <= sh_q[0]; // RL8
              `QEQ_REG_OLVL: olvl_q <= sh_q[`QEQ_OLVL_HI:`QEQ_OLVL_LO]; // RL16
              default: ;
            endcase
          end
        end
        S_WACK: begin
          oe_q <= 1'b0;
          cnt_q <= 3'h0;
          ptr_q <= ptr_q + 8'h01;
          st_q <= S_WDAT;
        end
        S_RDAT: begin
          if (cnt_q == 3'h0) begin
            oe_q <= 1'b0;
            st_q <= S_RACK;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
          end
        end
        S_RACK: begin
          cnt_q <= 3'h0;
          if (nack_q) begin
            st_q <= S_IDLE;
          end else begin
            tx_q <= rd_nxt;
            oe_q <= ~rd_nxt[7];
            ptr_q <= ptr_q + 8'h01;
            st_q <= S_RDAT;
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // channel control: boost and enable source selection
  // ----------------------------------------------------------------------
  assign reg_boost = {eb23_q[6:4], eb23_q[2:0], eb01_q[6:4], eb01_q[2:0]};

  always @* begin
    standby_d = 4'h0;
    boost_d = 12'h000;
    sd_d = sd_q;
    for (i = 0; i < 4; i = i + 1) begin
      if (ctrl_q)
        standby_d[i] = (i < 2) ? eb01_q[4 * i + 3] : eb23_q[4 * (i - 2) + 3]; // RL7
      else
        standby_d[i] = ~en_s[i]; // RL6
      if (feb_s)
        boost_d[3 * i +: 3] = bst_s; // RL3 RL5
      else
        boost_d[3 * i +: 3] = reg_boost[3 * i +: 3]; // RL4 RL5
      if (chan_amp_mv[8 * i +: 8] > on_mv(athr_q[2 * i +: 2]))
        sd_d[i] = 1'b1; // RL9
      else if (chan_amp_mv[8 * i +: 8] < off_mv(rthr_q[2 * i +: 2]))
        sd_d[i] = 1'b0; // RL9
    end
  end

  // registered datapath controls and detect state
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_q <= 4'h0;
      boost_q <= {4{`QEQ_BOOST_DEF}};
      lvl_q <= OLVL_RST[`QEQ_OLVL_HI:`QEQ_OLVL_LO];
      sd_q <= 4'h0;
    end else begin
      pwr_q <= ~standby_d; // RL2
      boost_q <= boost_d;
      lvl_q <= olvl_q; // RL16
      sd_q <= sd_d; // RL10
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign mgmt_bus_data_out = 1'b0;
  assign mgmt_bus_data_oe = oe_q;
  assign chan_powered = pwr_q;
  assign chan_boost = boost_q;
  assign out_level = lvl_q;
  assign signal_present_output = sd_q;

endmodule

`default_nettype wire

// ---- tb/qeq_mgmt_props.sv ----
/*
  Checker for the equalizer management block, bound to its top ports.
  Assumes one clk_sys domain with active-high asynchronous rst.
*/
`timescale 1ns/1ns
`default_nettype none
module qeq_mgmt_props #(
  parameter integer TMO_CYC = 200
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus pins
  input wire logic port_select_pin,
  input wire logic mgmt_bus_clock_pin,
  input wire logic mgmt_bus_data_out,
  input wire logic mgmt_bus_data_oe,
  // control pins and outputs
  input wire logic boost_source_pin,
  input wire logic [2:0] boost_level_pins,
  input wire logic [31:0] chan_amp_mv,
  input wire logic [11:0] chan_boost,
  input wire logic [1:0] out_level,
  input wire logic [3:0] signal_present_output
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [31:0] low_q;
  wire [7:0] amp2 = chan_amp_mv[23:16];
  // bus clock low time, saturating above the timeout
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_q <= 32'h0;
    end else if (mgmt_bus_clock_pin) begin
      low_q <= 32'h0;
    end else if (low_q < TMO_CYC + 16) begin
      low_q <= low_q + 32'h1;
    end
  end
  // pins steady long enough to pass the synchronisers
  sequence pins_held;
    (boost_source_pin && $stable(boost_level_pins)) [*5];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sel_gate_a: assert property (!port_select_pin [*6] |-> !mgmt_bus_data_oe)
    else $error("bus answered while port deselected");
  pull_low_a: assert property (mgmt_bus_data_oe |-> !mgmt_bus_data_out && $past(port_select_pin, 3))
    else $error("data driven high or without port select");
  oe_stable_a: assert property ($changed(mgmt_bus_data_oe) |-> !mgmt_bus_clock_pin)
    else $error("data moved while bus clock high");
  timeout_a: assert property (low_q >= TMO_CYC + 16 |-> !mgmt_bus_data_oe)
    else $error("data held after clock-low timeout");
  boost_pins_a: assert property (pins_held |-> chan_boost == {4{boost_level_pins}})
    else $error("boost not taken from pins");
  detect_set_a: assert property (amp2 > 8'h5A |-> ##[1:2] signal_present_output[2])
    else $error("detect not set above top threshold");
  detect_clear_a: assert property (amp2 < 8'h1E |-> ##[1:2] !signal_present_output[2])
    else $error("detect not cleared below lowest threshold");
  detect_rise_a: assert property ($rose(signal_present_output[2]) |-> $past(amp2) > 8'h37 || $past(amp2, 2) > 8'h37)
    else $error("detect rose without a large input");
  level_reset_a: assert property ($fell(rst) |-> out_level == 2'h2)
    else $error("output level not at its reset code");
  // main scenarios
  oe_seen_c: cover property ($rose(mgmt_bus_data_oe));
  detect_seen_c: cover property ($rose(signal_present_output[2]));
  level_max_c: cover property (out_level == 2'h3);
endmodule
bind qeq_mgmt qeq_mgmt_props #(.TMO_CYC(TMO_CYC)) qeq_mgmt_props_i (
  .clk_sys, .rst, .port_select_pin, .mgmt_bus_clock_pin, .mgmt_bus_data_out, .mgmt_bus_data_oe,
  .boost_source_pin, .boost_level_pins, .chan_amp_mv, .chan_boost, .out_level, .signal_present_output
);
`default_nettype wire

// ---- tb/qeq_host.sv ----
/*
  Bus host model: bus clock and open-drain data pull for the management port.
  Assumes the bench resolves the data wire and calls tasks 1 ns after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module qeq_host (
  // bus wires
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // ----------------------------------------
  // bus cycles, 160 ns bit time, clock idles high
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    #20 sda_drv = 1'b1;
    #60 scl = 1'b1;
    #80 sda_drv = 1'b0;
    #80 scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #20 sda_drv = 1'b0;
    #60 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #80;
  endtask
  // one bit, data moved only while clock low
  task automatic bit_io(input logic b, output logic r);
    #20 sda_drv = b;
    #60 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  // byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, ao);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench for the equalizer management block.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [6:0] ADDR = 7'h2C;
  localparam integer TMO = 200;
  logic clk_sys, rst, port_select_pin, boost_source_pin;
  logic [2:0] boost_level_pins;
  logic [3:0] channel_enable_pin;
  logic [31:0] chan_amp_mv;
  logic [6:0] tgt = ADDR;
  wire scl, sda_drv, oe;
  wire sda = oe ? 1'b0 : sda_drv;
  wire [3:0] chan_powered, sdo;
  wire [11:0] chan_boost;
  wire [1:0] out_level;
  int num_errors, n_checks, cycles;
  // revision value is arbitrary
  qeq_mgmt #(.BUS_ADDR(ADDR), .REVISION(4'hA), .TMO_CYC(TMO)) qeq_mgmt_i (
    .clk_sys, .rst, .port_select_pin, .mgmt_bus_clock_pin(scl), .mgmt_bus_data_in(sda),
    .mgmt_bus_data_out(), .mgmt_bus_data_oe(oe), .boost_source_pin, .boost_level_pins,
    .channel_enable_pin, .chan_amp_mv, .chan_powered, .chan_boost, .out_level, .signal_present_output(sdo));
  qeq_host qeq_host_i (.scl, .sda_drv, .sda);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic [2:0] a;
    qeq_host_i.start();
    qeq_host_i.xfer({tgt, 1'b0}, 1'b1, q, a[2]);
    qeq_host_i.xfer(o, 1'b1, q, a[1]);
    qeq_host_i.xfer(d, 1'b1, q, a[0]);
    qeq_host_i.stop();
    chk("write ack", a, {3{ea}});
  endtask
  task automatic rc(input logic [7:0] o, input logic [7:0] e);
    logic [7:0] q;
    logic [2:0] a;
    logic n;
    qeq_host_i.start();
    qeq_host_i.xfer({tgt, 1'b0}, 1'b1, q, a[2]);
    qeq_host_i.xfer(o, 1'b1, q, a[1]);
    qeq_host_i.start();
    qeq_host_i.xfer({tgt, 1'b1}, 1'b1, q, a[0]);
    qeq_host_i.xfer(8'hFF, 1'b1, q, n);
    qeq_host_i.stop();
    chk("read ack", a, 3'h0);
    chk("register", q, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rc(8'h00, 8'hA0);
    rc(8'h03, 8'h44);
    rc(8'h06, 8'h00);
    rc(8'h07, 8'h00);
    rc(8'h08, 8'h78);
    $display("reset done");
  endtask
  task automatic t_regs();
    wr(8'h08, 8'hFF, 1'b0);
    rc(8'h08, 8'h7C);
    chk("level", out_level, 2'h3);
    wr(8'h07, 8'hFE, 1'b0);
    rc(8'h07, 8'h00);
    wr(8'h00, 8'h0F, 1'b0);
    rc(8'h00, 8'hA0);
    wr(8'h0A, 8'h55, 1'b0);
    rc(8'h0A, 8'h00);
    $display("regs done");
  endtask
  task automatic t_boost();
    boost_level_pins = 3'h7;
    tick(6);
    chk("boost pins", chan_boost, 12'hFFF);
    boost_source_pin = 1'b0;
    wr(8'h03, 8'h70, 1'b0);
    wr(8'h04, 8'h21, 1'b0);
    chk("boost regs", chan_boost, 12'h478);
    rc(8'h01, 8'h70);
    rc(8'h02, 8'h21);
    $display("boost done");
  endtask
  task automatic t_enable();
    channel_enable_pin = 4'h5;
    wr(8'h03, 8'h80, 1'b0);
    wr(8'h04, 8'h08, 1'b0);
    chk("powered pins", chan_powered, 4'h5);
    wr(8'h07, 8'h01, 1'b0);
    chk("powered regs", chan_powered, 4'h9);
    rc(8'h01, 8'h80);
    rc(8'h02, 8'h08);
    wr(8'h07, 8'h00, 1'b0);
    $display("enable done");
  endtask
  task automatic t_detect();
    wr(8'h05, 8'hE4, 1'b0);
    wr(8'h06, 8'hE4, 1'b0);
    chan_amp_mv = {8'h4B, 8'h5A, 8'h37, 8'h46};
    tick(4);
    chk("detect equal", sdo, 4'h0);
    chan_amp_mv = {8'h4C, 8'h5B, 8'h38, 8'h47};
    tick(4);
    chk("detect above", sdo, 4'hF);
    chan_amp_mv = {8'h2D, 8'h37, 8'h1E, 8'h28};
    tick(4);
    chk("detect hold", sdo, 4'hF);
    chan_amp_mv = {8'h2C, 8'h36, 8'h1D, 8'h27};
    tick(4);
    chk("detect release", sdo, 4'h0);
    chan_amp_mv = {8'h4C, 24'h0};
    tick(4);
    rc(8'h00, 8'hA8);
    boost_source_pin = 1'b1;
    channel_enable_pin = sdo;
    tick(5);
    chk("auto enable", chan_powered, 4'h8);
    $display("detect done");
  endtask
  task automatic t_select();
    logic [7:0] q;
    logic a;
    port_select_pin = 1'b0;
    tick(4);
    wr(8'h07, 8'h01, 1'b1);
    port_select_pin = 1'b1;
    tgt = 7'h11;
    wr(8'h07, 8'h01, 1'b1);
    tgt = ADDR;
    rc(8'h07, 8'h00);
    qeq_host_i.start();
    qeq_host_i.xfer({ADDR, 1'b0}, 1'b1, q, a);
    for (int i = 7; i >= 0; i--) begin
      qeq_host_i.bit_io(i < 3, a);
    end
    tick(5);
    chk("ack held", oe, 1'b1);
    tick(TMO + 20);
    chk("timeout release", oe, 1'b0);
    qeq_host_i.stop();
    rc(8'h07, 8'h00);
    $display("select done");
  endtask
  // ----------------------------------------
  // clock, run limit and main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    port_select_pin = 1'b1;
    boost_source_pin = 1'b1;
    boost_level_pins = 3'h4;
    channel_enable_pin = 4'hF;
    chan_amp_mv = 32'h0;
    tick(3);
    chk("reset boost", chan_boost, 12'h924);
    tick(2);
    rst = 1'b0;
    tick(6);
    t_reset();
    t_regs();
    t_boost();
    t_enable();
    t_detect();
    t_select();
    close_out();
  end
endmodule
`default_nettype wire
